// *** ncfg_regs.vh ***
// Address map, field positions and reset values of the configuration space
`ifndef NCFG_REGS_VH
`define NCFG_REGS_VH

`define NCFG_ADDR_W          24
`define NCFG_WORD_W          24
`define NCFG_ADDR_OSC        24'hf80000
`define NCFG_ADDR_WDT        24'hf80002
`define NCFG_ADDR_RSTPWM     24'hf80004
`define NCFG_ADDR_SEGPROT    24'hf8000a
`define NCFG_ADDR_ID_LOW     24'hff0000
`define NCFG_ADDR_ID_HIGH    24'hff0002
`define NCFG_UNIT_ID_FIRST   24'h800600
`define NCFG_UNIT_ID_LAST    24'h80063e
`define NCFG_UNIT_ID_WORDS   32
`define NCFG_IVT_LAST        24'h0000fe
`define NCFG_USER_LAST       24'h7fffff

// Implemented-bit masks; all other bits read as zero
`define NCFG_MASK_OSC        24'h00ffff
`define NCFG_MASK_WDT        24'h00803f
`define NCFG_MASK_RSTPWM     24'h0087b3
`define NCFG_MASK_SEGPROT    24'h000003

// Field positions
`define NCFG_WDT_EN_BIT      15
`define NCFG_WDT_PSA_HI      5
`define NCFG_WDT_PSA_LO      4
`define NCFG_WDT_PSB_HI      3
`define NCFG_WDT_PSB_LO      0
`define NCFG_RST_PIN_BIT     15
`define NCFG_PWM_PIN_BIT     10
`define NCFG_HIGH_SIDE_POLARITY_BIT        9
`define NCFG_LOW_SIDE_POLARITY_BIT        8
`define NCFG_BOR_EN_BIT      7
`define NCFG_BROWNOUT_THRESHOLD_SELECT_HI         5
`define NCFG_BROWNOUT_THRESHOLD_SELECT_LO         4
`define NCFG_POWERUP_TIMER_HI         1
`define NCFG_POWERUP_TIMER_LO         0
`define NCFG_GCP_BIT         1
`define NCFG_SEGMENT_WRITE_PROTECT_BIT        0

// Erased state: every stored bit is one; implemented bits read one
`define NCFG_ERASED_WORD     24'hffffff

// Prescaler A ratios and power-up times in ms
`define NCFG_PSA_DIV3        10'h200
`define NCFG_PSA_DIV2        10'h040
`define NCFG_PSA_DIV1        10'h008
`define NCFG_PSA_DIV0        10'h001
`define NCFG_POWERUP_TIMER_MS3        7'h40
`define NCFG_POWERUP_TIMER_MS2        7'h10
`define NCFG_POWERUP_TIMER_MS1        7'h04
`define NCFG_POWERUP_TIMER_MS0        7'h00

// Operation codes on i_op
`define NCFG_OP_READ         3'h0
`define NCFG_OP_PROGRAM      3'h1
`define NCFG_OP_SEG_ERASE    3'h2
`define NCFG_OP_CHIP_ERASE   3'h3
`define NCFG_OP_W            3

// Requesters on i_src
`define NCFG_SRC_TABLE       2'h0
`define NCFG_SRC_PSV         2'h1
`define NCFG_SRC_SELFPROG    2'h2
`define NCFG_SRC_SERIAL      2'h3

// Answer status codes
`define NCFG_ST_OK           2'h0
`define NCFG_ST_DENIED       2'h1
`define NCFG_ST_UNMAPPED     2'h2

`endif

// *** ncfg_cell.v ***
// One nonvolatile configuration word with program-only-to-zero semantics
`timescale 1ns/100ps
`default_nettype none
`include "ncfg_regs.vh"

module ncfg_cell
#(
   parameter [23:0] MASK = 24'h00ffff
)
(
   input  wire        i_clock,
   input  wire        i_program,
   input  wire        i_erase,
   input  wire [23:0] i_data,
   output wire [23:0] o_word
);

   reg [23:0] cell_r;

   // Storage survives reset, so no reset term; starts erased
   initial cell_r = `NCFG_ERASED_WORD;

   always @(posedge i_clock)
   begin
      if (i_erase)
         cell_r <= `NCFG_ERASED_WORD;
      else if (i_program)
         cell_r <= cell_r & i_data;
   end

   assign o_word = cell_r & MASK;

endmodule // ncfg_cell

`default_nettype wire

// *** ncfg_space.v ***
// Nonvolatile configuration space: words, decode, protection and access gate
// Behaviour
// - A programmed bit reads 0, an erased bit reads 1; behaviour follows reads.
// - Each word is 24 bits wide; only bits 15..0 hold settings.
// - Words sit at f80000, f80002, f80004, f8000a; readable during operation.
// - Watchdog fuse set forces watchdog and RC oscillator on; software clear ignored.
// - Prescaler A bits 5..4 select 512, 64, 8 or 1.
// - Prescaler B bits 3..0 divide by field value plus one.
// - Reset word bit 15 set gives the reset pin its reset function.
// - Bit 10 chooses tri-stated port pins or driven PWM pins at reset.
// - Bit 9 sets high-side PWM polarity, one meaning active high.
// - Bit 8 sets low-side PWM polarity independently, one meaning active high.
// - Bit 7 enables the brown-out reset.
// - Bits 5..4 drive the brown-out threshold select.
// - Bits 1..0 pick power-up hold 64, 16, 4 ms or off.
// - Code protect zero refuses program memory reads to the serial port.
// - Protected segment refuses programming until the segment is erased.
// - Table reads and visibility accesses still read protected memory.
// - Write protect programmed blocks all user program memory writes.
// - Protection covers user memory except the vector table range.
// - Protect bits change as a group, to zero only; chip erase restores.
// - Two identification words are read-only and table-readable.
// - Unit ID field of 32 words is readable, never writable or erasable.
`timescale 1ns/100ps
`default_nettype none
`include "ncfg_regs.vh"

module ncfg_space
#(
   parameter [23:0] ID_LOW_VALUE  = 24'h00a5a5, // Arbitrary value
   parameter [23:0] ID_HIGH_VALUE = 24'h000001, // Arbitrary value
   parameter [23:0] UNIT_ID_SEED  = 24'h000000  // Arbitrary value
)
(
   input  wire                   i_clock,
   input  wire                   i_rst,
   input  wire                   i_req,
   input  wire [`NCFG_OP_W-1:0]  i_op,
   input  wire [1:0]             i_src,
   input  wire [23:0]            i_addr,
   input  wire [23:0]            i_wdata,
   input  wire                   i_software_watchdog_enable,
   input  wire                   i_seg_erased,
   output reg                    o_ack,
   output reg  [1:0]             o_status,
   output reg  [23:0]            o_rdata,
   output reg                    o_user_mem_we,
   output reg                    o_user_mem_re,
   output reg  [23:0]            o_user_mem_addr,
   output reg  [23:0]            o_user_mem_wdata,
   output reg                    o_watchdog_run,
   output reg                    o_low_power_rc_oscillator_on,
   output reg  [9:0]             o_watchdog_prescale_a_div,
   output reg  [4:0]             o_watchdog_prescale_b_div,
   output reg                    o_reset_pin_function_enable,
   output reg                    o_motor_pwm_pins_driven,
   output reg                    o_high_side_active_high,
   output reg                    o_low_side_active_high,
   output reg                    o_brownout_enable,
   output reg  [1:0]             o_brownout_threshold_select,
   output reg  [6:0]             o_powerup_timer_ms,
   output reg                    o_segment_code_protected,
   output reg                    o_segment_write_protected
);

   wire [23:0] osc_word;
   wire [23:0] wdt_word;
   wire [23:0] rst_word;
   wire [23:0] seg_word;
   reg  [3:0]  prog_sel;
   reg         erase_all;
   reg  [23:0] unit_id_mem [0:`NCFG_UNIT_ID_WORDS-1];
   integer     k;

   wire is_read  = i_req && (i_op == `NCFG_OP_READ);
   wire is_prog  = i_req && (i_op == `NCFG_OP_PROGRAM);
   wire is_serr  = i_req && (i_op == `NCFG_OP_SEG_ERASE);
   wire is_cerr  = i_req && (i_op == `NCFG_OP_CHIP_ERASE);
   wire code_prot  = ~seg_word[`NCFG_GCP_BIT];
   wire write_prot = ~seg_word[`NCFG_SEGMENT_WRITE_PROTECT_BIT];
   // Segment erase seen after protection; a program attempt is allowed once this is set
   reg  seg_cleared_r;

   // vector table lies outside the segment
   wire in_user = (i_addr > `NCFG_IVT_LAST) && (i_addr <= `NCFG_USER_LAST);
   wire in_ivt  = (i_addr <= `NCFG_IVT_LAST);
   wire in_uid  = (i_addr >= `NCFG_UNIT_ID_FIRST) && (i_addr <= `NCFG_UNIT_ID_LAST);
   wire [4:0] uid_idx = i_addr[5:1];
   wire from_ext = (i_src == `NCFG_SRC_SERIAL);
   wire from_cpu = (i_src == `NCFG_SRC_TABLE) || (i_src == `NCFG_SRC_PSV);

   // protect group: any zero locks both bits until chip erase
   wire seg_group_locked = code_prot || write_prot;

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_cell
         localparam [23:0] CM = (g == 0) ? `NCFG_MASK_OSC :
                                (g == 1) ? `NCFG_MASK_WDT :
                                (g == 2) ? `NCFG_MASK_RSTPWM : `NCFG_MASK_SEGPROT;
         wire [23:0] w;
         ncfg_cell #(.MASK(CM)) u_cell
         (
            .i_clock   (i_clock),
            .i_program (prog_sel[g]),
            .i_erase   (erase_all),
            .i_data    (i_wdata),
            .o_word    (w)
         );
      end
   endgenerate

   assign osc_word = g_cell[0].w;
   assign wdt_word = g_cell[1].w;
   assign rst_word = g_cell[2].w;
   assign seg_word = g_cell[3].w;

   // Programming strobes into the configuration words
   always @*
   begin
      prog_sel  = 4'h0;
      erase_all = is_cerr && !i_rst;
      if (is_prog && !i_rst && !from_cpu)
      begin
         // all 24 bits reach storage; the cell mask limits what reads back
         case (i_addr)
            `NCFG_ADDR_OSC:     prog_sel = 4'h1;
            `NCFG_ADDR_WDT:     prog_sel = 4'h2;
            `NCFG_ADDR_RSTPWM:  prog_sel = 4'h4;
            // group write refused once either bit is zero
            `NCFG_ADDR_SEGPROT: prog_sel = seg_group_locked ? 4'h0 : 4'h8;
            default:            prog_sel = 4'h0;
         endcase
      end
   end

   // Factory content of the unit ID field; no write path exists
   initial
   begin
      for (k = 0; k < `NCFG_UNIT_ID_WORDS; k = k + 1)
         unit_id_mem[k] = UNIT_ID_SEED + k[23:0];
   end

   // Access gate and answer
   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_ack            <= 1'b0;
         o_status         <= `NCFG_ST_OK;
         o_rdata          <= 24'h000000;
         o_user_mem_we    <= 1'b0;
         o_user_mem_re    <= 1'b0;
         o_user_mem_addr  <= 24'h000000;
         o_user_mem_wdata <= 24'h000000;
         seg_cleared_r    <= 1'b0;
      end
      else
      begin
         o_ack         <= i_req;
         o_status      <= `NCFG_ST_OK;
         o_rdata       <= 24'h000000;
         o_user_mem_we <= 1'b0;
         o_user_mem_re <= 1'b0;
         if (i_req)
         begin
            o_user_mem_addr  <= i_addr;
            o_user_mem_wdata <= i_wdata & 24'h00ffff;
         end
         if (is_cerr)
            seg_cleared_r <= 1'b0;
         else if (is_serr && code_prot)
            seg_cleared_r <= 1'b1;
         else if (i_seg_erased && code_prot)
            seg_cleared_r <= 1'b1;
         if (is_read)
         begin
            case (i_addr)
               // configuration words readable in normal operation
               `NCFG_ADDR_OSC:     o_rdata <= osc_word;
               `NCFG_ADDR_WDT:     o_rdata <= wdt_word;
               `NCFG_ADDR_RSTPWM:  o_rdata <= rst_word;
               `NCFG_ADDR_SEGPROT: o_rdata <= seg_word;
               `NCFG_ADDR_ID_LOW:  o_rdata <= ID_LOW_VALUE;
               `NCFG_ADDR_ID_HIGH: o_rdata <= ID_HIGH_VALUE;
               default:
               begin
                  if (in_uid && !i_addr[0])
                     o_rdata <= unit_id_mem[uid_idx];
                  else if (in_ivt)
                     o_user_mem_re <= 1'b1;
                  else if (in_user)
                  begin
                     // external readout refused under code protect
                     if (from_ext && code_prot)
                        o_status <= `NCFG_ST_DENIED;
                     else
                        o_user_mem_re <= 1'b1;
                  end
                  else
                     o_status <= `NCFG_ST_UNMAPPED;
               end
            endcase
         end
         else if (is_prog)
         begin
            if (from_cpu)
               o_status <= `NCFG_ST_DENIED;
            // ID and unit ID locations never written
            else if (in_uid || i_addr == `NCFG_ADDR_ID_LOW || i_addr == `NCFG_ADDR_ID_HIGH)
               o_status <= `NCFG_ST_DENIED;
            else if (i_addr == `NCFG_ADDR_SEGPROT && seg_group_locked)
               o_status <= `NCFG_ST_DENIED;
            else if (in_ivt)
               o_user_mem_we <= 1'b1;
            else if (in_user)
            begin
               // write protect blocks every user write
               if (write_prot)
                  o_status <= `NCFG_ST_DENIED;
               else if (code_prot && !seg_cleared_r)
                  o_status <= `NCFG_ST_DENIED;
               else
                  o_user_mem_we <= 1'b1;
            end
            else if (prog_sel == 4'h0)
               o_status <= `NCFG_ST_UNMAPPED;
         end
         else if (is_serr && in_uid)
            o_status <= `NCFG_ST_DENIED;
      end
   end

   // Decoded settings, registered straight to the outputs
   always @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_watchdog_run               <= 1'b1;
         o_low_power_rc_oscillator_on <= 1'b1;
         o_watchdog_prescale_a_div    <= `NCFG_PSA_DIV3;
         o_watchdog_prescale_b_div    <= 5'h10;
         o_reset_pin_function_enable  <= 1'b1;
         o_motor_pwm_pins_driven      <= 1'b0;
         o_high_side_active_high      <= 1'b1;
         o_low_side_active_high       <= 1'b1;
         o_brownout_enable            <= 1'b1;
         o_brownout_threshold_select  <= 2'h3;
         o_powerup_timer_ms           <= `NCFG_POWERUP_TIMER_MS3;
         o_segment_code_protected     <= 1'b0;
         o_segment_write_protected    <= 1'b0;
      end
      else
      begin
         // fuse forces watchdog and RC source on
         o_watchdog_run <= wdt_word[`NCFG_WDT_EN_BIT] | i_software_watchdog_enable;
         o_low_power_rc_oscillator_on <= wdt_word[`NCFG_WDT_EN_BIT] | i_software_watchdog_enable;
         case (wdt_word[`NCFG_WDT_PSA_HI:`NCFG_WDT_PSA_LO])
            2'h3:    o_watchdog_prescale_a_div <= `NCFG_PSA_DIV3;
            2'h2:    o_watchdog_prescale_a_div <= `NCFG_PSA_DIV2;
            2'h1:    o_watchdog_prescale_a_div <= `NCFG_PSA_DIV1;
            default: o_watchdog_prescale_a_div <= `NCFG_PSA_DIV0;
         endcase
         // prescaler B is field plus one
         o_watchdog_prescale_b_div <= {1'b0, wdt_word[`NCFG_WDT_PSB_HI:`NCFG_WDT_PSB_LO]} + 5'h01;
         o_reset_pin_function_enable <= rst_word[`NCFG_RST_PIN_BIT];
         // zero hands pins to the PWM module
         o_motor_pwm_pins_driven <= ~rst_word[`NCFG_PWM_PIN_BIT];
         o_high_side_active_high <= rst_word[`NCFG_HIGH_SIDE_POLARITY_BIT];
         o_low_side_active_high <= rst_word[`NCFG_LOW_SIDE_POLARITY_BIT];
         o_brownout_enable <= rst_word[`NCFG_BOR_EN_BIT];
         o_brownout_threshold_select <= rst_word[`NCFG_BROWNOUT_THRESHOLD_SELECT_HI:`NCFG_BROWNOUT_THRESHOLD_SELECT_LO];
         case (rst_word[`NCFG_POWERUP_TIMER_HI:`NCFG_POWERUP_TIMER_LO])
            2'h3:    o_powerup_timer_ms <= `NCFG_POWERUP_TIMER_MS3;
            2'h2:    o_powerup_timer_ms <= `NCFG_POWERUP_TIMER_MS2;
            2'h1:    o_powerup_timer_ms <= `NCFG_POWERUP_TIMER_MS1;
            default: o_powerup_timer_ms <= `NCFG_POWERUP_TIMER_MS0;
         endcase
         o_segment_code_protected  <= code_prot;
         o_segment_write_protected <= write_prot;
      end
   end

endmodule // ncfg_space

`default_nettype wire

// *** ncfg_monitor.sv ***
// Concurrent checks on the configuration space ports
`timescale 1ns/100ps
`default_nettype none
`include "ncfg_regs.vh"
module ncfg_monitor
(
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_req,
   input wire logic [2:0]  i_op,
   input wire logic [1:0]  i_src,
   input wire logic [23:0] i_addr,
   input wire logic        i_software_watchdog_enable,
   input wire logic        o_ack,
   input wire logic [1:0]  o_status,
   input wire logic [23:0] o_rdata,
   input wire logic        o_user_mem_we,
   input wire logic        o_user_mem_re,
   input wire logic        o_watchdog_run,
   input wire logic [9:0]  o_watchdog_prescale_a_div,
   input wire logic        o_segment_code_protected,
   input wire logic        o_segment_write_protected
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   wire user = i_addr > `NCFG_IVT_LAST && i_addr <= `NCFG_USER_LAST;
   sequence s_rd(logic [1:0] s);
      i_req && i_op == `NCFG_OP_READ && i_src == s && user;
   endsequence
   // Protection flags lag the words, so only judge after two idle cycles
   sequence s_quiet;
      !$past(i_req) && !$past(i_req, 2);
   endsequence
   sequence s_uprog;
      i_req && i_op == `NCFG_OP_PROGRAM && user;
   endsequence
   property p_ack;
      i_req |=> o_ack;
   endproperty
   property p_mask;
      i_req && i_op == `NCFG_OP_READ && i_addr == `NCFG_ADDR_WDT |=> (o_rdata & ~`NCFG_MASK_WDT) == 24'h0;
   endproperty
   property p_run;
      i_software_watchdog_enable |=> o_watchdog_run;
   endproperty
   property p_psa;
      $onehot(o_watchdog_prescale_a_div) && (o_watchdog_prescale_a_div & 10'h1b6) == 10'h0;
   endproperty
   property p_serial;
      s_rd(`NCFG_SRC_SERIAL) ##0 s_quiet ##0 o_segment_code_protected && $past(o_segment_code_protected)
         |=> o_status == `NCFG_ST_DENIED && !o_user_mem_re;
   endproperty
   property p_table;
      s_rd(`NCFG_SRC_TABLE) |=> o_status == `NCFG_ST_OK && o_user_mem_re;
   endproperty
   property p_wp;
      s_uprog ##0 s_quiet ##0 o_segment_write_protected && $past(o_segment_write_protected) |=> !o_user_mem_we;
   endproperty
   property p_ivt;
      i_req && i_op == `NCFG_OP_PROGRAM && i_src == `NCFG_SRC_SELFPROG && i_addr <= `NCFG_IVT_LAST
         |=> o_user_mem_we && o_status == `NCFG_ST_OK;
   endproperty
   property p_uid;
      i_req && i_op inside {`NCFG_OP_PROGRAM, `NCFG_OP_SEG_ERASE}
         && i_addr inside {[`NCFG_UNIT_ID_FIRST:`NCFG_UNIT_ID_LAST]} |=> o_status == `NCFG_ST_DENIED && !o_user_mem_we;
   endproperty
   a_ack: assert property (p_ack)
      else $error("request not answered");
   a_mask: assert property (p_mask)
      else $error("unimplemented bits read nonzero");
   a_run: assert property (p_run)
      else $error("watchdog stopped while enabled");
   a_psa: assert property (p_psa)
      else $error("illegal prescaler A ratio");
   a_serial: assert property (p_serial)
      else $error("protected memory read by serial port");
   a_table: assert property (p_table)
      else $error("table read refused");
   a_wp: assert property (p_wp)
      else $error("write passed write protection");
   a_ivt: assert property (p_ivt)
      else $error("vector table write refused");
   a_uid: assert property (p_uid)
      else $error("unit id altered");
endmodule // ncfg_monitor
bind ncfg_space ncfg_monitor i_mon
(
   .i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .i_op(i_op), .i_src(i_src), .i_addr(i_addr),
   .i_software_watchdog_enable(i_software_watchdog_enable), .o_ack(o_ack), .o_status(o_status),
   .o_rdata(o_rdata), .o_user_mem_we(o_user_mem_we), .o_user_mem_re(o_user_mem_re),
   .o_watchdog_run(o_watchdog_run), .o_watchdog_prescale_a_div(o_watchdog_prescale_a_div),
   .o_segment_code_protected(o_segment_code_protected), .o_segment_write_protected(o_segment_write_protected)
);
`default_nettype wire

// *** nonvolatile_config_space_tb_top.sv ***
// Scenario testbench of the configuration space
`timescale 1ns/100ps
`default_nettype none
`include "ncfg_regs.vh"
module nonvolatile_config_space_tb_top;
   localparam [23:0] IDL = 24'h00c3c3; // Arbitrary value
   localparam [23:0] IDH = 24'h000007; // Arbitrary value
   logic        clk;
   logic        rst = 1'b1;
   logic        req = 1'b0;
   logic        sw = 1'b0;
   logic [2:0]  op = 3'h0;
   logic [1:0]  src = 2'h0;
   logic [23:0] addr = 24'h0;
   logic [23:0] wd = 24'h0;
   wire         ack, we, re, run, low_power_rc_oscillator, pin, drv, hp, lp, bor, cp, wp;
   wire  [1:0]  st, bv;
   wire  [23:0] rd, mw;
   wire  [9:0]  pa;
   wire  [4:0]  pb;
   wire  [6:0]  pt;
   int          fails = 0;
   int          cmp_count = 0;
   logic [1:0]  q_st;
   logic [23:0] q_rd;
   logic        q_stb;

   ncfg_space #(.ID_LOW_VALUE(IDL), .ID_HIGH_VALUE(IDH)) i_dut
   (
      .i_clock(clk), .i_rst(rst), .i_req(req), .i_op(op), .i_src(src), .i_addr(addr), .i_wdata(wd),
      .i_software_watchdog_enable(sw), .i_seg_erased(1'b0), .o_ack(ack), .o_status(st), .o_rdata(rd),
      .o_user_mem_we(we), .o_user_mem_re(re), .o_user_mem_addr(), .o_user_mem_wdata(mw),
      .o_watchdog_run(run), .o_low_power_rc_oscillator_on(low_power_rc_oscillator), .o_watchdog_prescale_a_div(pa),
      .o_watchdog_prescale_b_div(pb), .o_reset_pin_function_enable(pin), .o_motor_pwm_pins_driven(drv),
      .o_high_side_active_high(hp), .o_low_side_active_high(lp), .o_brownout_enable(bor),
      .o_brownout_threshold_select(bv), .o_powerup_timer_ms(pt), .o_segment_code_protected(cp),
      .o_segment_write_protected(wp)
   );

   task chk(input string n, input logic [23:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   // Strobe stands one edge; the answer is registered on that same edge
   task rq(input logic [2:0] o, input logic [1:0] s, input logic [23:0] a, d);
      @(posedge clk) #1;
      req = 1'b1;
      op = o;
      src = s;
      addr = a;
      wd = d;
      @(posedge clk) #1;
      req = 1'b0;
      q_st = st;
      q_rd = rd;
      q_stb = we | re;
      chk("ack", 24'h1, 24'(ack));
   endtask

   task rs(input logic [2:0] o, input logic [1:0] s, input logic [23:0] a, d, input logic [1:0] es, input logic eb);
      rq(o, s, a, d);
      chk("status", 24'(es), 24'(q_st));
      chk("strobe", 24'(eb), 24'(q_stb));
   endtask

   task pg(input logic [1:0] s, input logic [23:0] a, d, input logic [1:0] es, input logic eb);
      rs(`NCFG_OP_PROGRAM, s, a, d, es, eb);
   endtask

   task ce;
      rq(`NCFG_OP_CHIP_ERASE, `NCFG_SRC_SERIAL, 24'h0, 24'h0);
   endtask

   task t_erased;
      logic [23:0] ad[4] = '{`NCFG_ADDR_OSC, `NCFG_ADDR_WDT, `NCFG_ADDR_RSTPWM, `NCFG_ADDR_SEGPROT};
      logic [23:0] mk[4] = '{`NCFG_MASK_OSC, `NCFG_MASK_WDT, `NCFG_MASK_RSTPWM, `NCFG_MASK_SEGPROT};
      for (int i = 0; i < 4; i++)
      begin
         rs(`NCFG_OP_READ, `NCFG_SRC_TABLE, ad[i], 24'h0, `NCFG_ST_OK, 1'b0);
         chk("erased word", mk[i], q_rd);
      end
      chk("erased decode", 24'({10'h200, 5'h10, 7'h40}), 24'({pa, pb, pt}));
   endtask

   task t_wdt;
      logic [9:0] da[4] = '{10'h001, 10'h008, 10'h040, 10'h200};
      logic [1:0] c;
      logic [3:0] b;
      for (int k = 0; k < 4; k++)
      begin
         c = 2'(k);
         b = 4'(k * 5);
         ce;
         pg(`NCFG_SRC_SERIAL, `NCFG_ADDR_WDT, {16'hff7f, 2'b11, c, b}, `NCFG_ST_OK, 1'b0);
         rs(`NCFG_OP_READ, `NCFG_SRC_TABLE, `NCFG_ADDR_WDT, 24'h0, `NCFG_ST_OK, 1'b0);
         chk("wdt word", {18'h0, c, b}, q_rd);
         chk("prescale", 24'({da[c], 5'(b + 1)}), 24'({pa, pb}));
         sw = c[0];
         @(posedge clk) #1;
         chk("run off fuse", 24'({sw, sw}), 24'({run, low_power_rc_oscillator}));
      end
      ce;
      sw = 1'b0;
      @(posedge clk) #1;
      chk("run fuse", 24'h3, 24'({run, low_power_rc_oscillator}));
   endtask

   task t_rst;
      logic [6:0]  ms[4] = '{7'h00, 7'h04, 7'h10, 7'h40};
      logic [1:0]  c;
      logic [23:0] w;
      for (int k = 0; k < 4; k++)
      begin
         c = 2'(k);
         w = {8'hff, c[0], 4'hf, c[1], c[0], ~c[0], ~c[1], 1'b1, c, 2'b11, c};
         ce;
         pg(`NCFG_SRC_SELFPROG, `NCFG_ADDR_RSTPWM, w, `NCFG_ST_OK, 1'b0);
         rs(`NCFG_OP_READ, `NCFG_SRC_SERIAL, `NCFG_ADDR_RSTPWM, 24'h0, `NCFG_ST_OK, 1'b0);
         chk("rst word", w & `NCFG_MASK_RSTPWM, q_rd);
         chk("rst decode", 24'({c[0], ~c[1], c[0], ~c[0], ~c[1], c, ms[c]}),
             24'({pin, drv, hp, lp, bor, bv, pt}));
      end
   endtask

   task t_prot;
      ce;
      pg(`NCFG_SRC_SERIAL, `NCFG_ADDR_SEGPROT, 24'hfffffd, `NCFG_ST_OK, 1'b0);
      @(posedge clk) #1;
      rs(`NCFG_OP_READ, `NCFG_SRC_SERIAL, 24'h000100, 24'h0, `NCFG_ST_DENIED, 1'b0);
      chk("flags", 24'h2, 24'({cp, wp}));
      rs(`NCFG_OP_READ, `NCFG_SRC_TABLE, 24'h000100, 24'h0, `NCFG_ST_OK, 1'b1);
      rs(`NCFG_OP_READ, `NCFG_SRC_PSV, 24'h7fffff, 24'h0, `NCFG_ST_OK, 1'b1);
      rs(`NCFG_OP_READ, `NCFG_SRC_SERIAL, 24'h0000fe, 24'h0, `NCFG_ST_OK, 1'b1);
      pg(`NCFG_SRC_SELFPROG, 24'h000200, 24'h00abcd, `NCFG_ST_DENIED, 1'b0);
      pg(`NCFG_SRC_SELFPROG, 24'h000010, 24'h00abcd, `NCFG_ST_OK, 1'b1);
      pg(`NCFG_SRC_SERIAL, `NCFG_ADDR_SEGPROT, 24'hfffffc, `NCFG_ST_DENIED, 1'b0);
      rq(`NCFG_OP_SEG_ERASE, `NCFG_SRC_SERIAL, 24'h000200, 24'h0);
      pg(`NCFG_SRC_SELFPROG, 24'h000200, 24'h001234, `NCFG_ST_OK, 1'b1);
      chk("wdata", 24'h001234, mw);
      ce;
      pg(`NCFG_SRC_SERIAL, `NCFG_ADDR_SEGPROT, 24'hfffffe, `NCFG_ST_OK, 1'b0);
      @(posedge clk) #1;
      pg(`NCFG_SRC_SELFPROG, 24'h000300, 24'h0, `NCFG_ST_DENIED, 1'b0);
      chk("flags", 24'h1, 24'({cp, wp}));
      ce;
      @(posedge clk) #1;
      chk("flags", 24'h0, 24'({cp, wp}));
   endtask

   task t_ids;
      rs(`NCFG_OP_READ, `NCFG_SRC_TABLE, `NCFG_ADDR_ID_LOW, 24'h0, `NCFG_ST_OK, 1'b0);
      chk("id low", IDL, q_rd);
      pg(`NCFG_SRC_SELFPROG, `NCFG_ADDR_ID_HIGH, 24'h0, `NCFG_ST_DENIED, 1'b0);
      rs(`NCFG_OP_READ, `NCFG_SRC_TABLE, `NCFG_ADDR_ID_HIGH, 24'h0, `NCFG_ST_OK, 1'b0);
      chk("id high", IDH, q_rd);
      rs(`NCFG_OP_READ, `NCFG_SRC_TABLE, `NCFG_UNIT_ID_LAST, 24'h0, `NCFG_ST_OK, 1'b0);
      pg(`NCFG_SRC_SERIAL, `NCFG_UNIT_ID_FIRST, 24'h0, `NCFG_ST_DENIED, 1'b0);
      rs(`NCFG_OP_SEG_ERASE, `NCFG_SRC_SERIAL, `NCFG_UNIT_ID_LAST, 24'h0, `NCFG_ST_DENIED, 1'b0);
      rs(`NCFG_OP_READ, `NCFG_SRC_TABLE, 24'hf80006, 24'h0, `NCFG_ST_UNMAPPED, 1'b0);
   endtask

   task end_sim;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial
   begin
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      t_erased;
      t_wdt;
      t_rst;
      t_prot;
      t_ids;
      end_sim;
   end

   // Whole run needs well under a thousand cycles
   initial
   begin
      #1000000;
      fails++;
      end_sim;
   end
endmodule // nonvolatile_config_space_tb_top
`default_nettype wire
